// ### hdl/fels_bus_cycle.sv
`timescale 1ns/1ps
`default_nettype none
`include "fels_defs.svh"
module fels_bus_cycle
  import fels_pkg::*;
#(
  parameter logic [7:0] STROBE_CYC =
    8'((`FELS_STROBE_NS + `FELS_CLK_NS - 1) / `FELS_CLK_NS),
  parameter logic [7:0] ACCESS_CYC =
    8'((`FELS_ACCESS_NS + `FELS_CLK_NS - 1) / `FELS_CLK_NS)
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic start,
  input wire fels_cyc_s cyc,
  input wire logic [`FELS_DATA_W-1:0] dqIn,
  output fels_pins_s pins,
  output logic done,
  output logic [`FELS_DATA_W-1:0] rdata
);
  fels_cyc_e state, next_state;
  fels_pins_s next_pins;
  logic next_done;
  logic [`FELS_DATA_W-1:0] next_rdata;
  logic [7:0] cnt, next_cnt;
  logic isWr, next_isWr;

  always_comb begin
    next_state = state;
    next_pins = pins;
    next_done = 1'b0;
    next_rdata = rdata;
    next_cnt = cnt;
    next_isWr = isWr;
    case (state)
      CY_IDLE: begin
        if (start) begin
          next_isWr = cyc.wr;
          next_pins.addr = cyc.addr;
          next_pins.dq = cyc.data;
          next_pins.dqDriveN = ~cyc.wr;
          next_pins.ceN = 1'b0;
          next_state = CY_SETUP;
        end
      end
      CY_SETUP: begin
        next_pins.weN = ~isWr;
        next_pins.oeN = isWr;
        next_cnt = isWr ? STROBE_CYC : ACCESS_CYC;
        next_state = CY_STROBE;
      end
      CY_STROBE: begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h01) begin
          // Rising write strobe here marks the end of a command write
          next_pins.weN = 1'b1;
          next_pins.oeN = 1'b1;
          if (!isWr) begin
            next_rdata = dqIn;
          end
          next_state = CY_HOLD;
        end
      end
      CY_HOLD: begin
        // Data held one cycle past the strobe for hold time
        next_pins.ceN = 1'b1;
        next_pins.dqDriveN = 1'b1;
        next_done = 1'b1;
        next_state = CY_IDLE;
      end
      default: next_state = CY_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= CY_IDLE;
      pins <= '{addr: '0, dq: '0, dqDriveN: 1'b1, ceN: 1'b1, oeN: 1'b1,
                weN: 1'b1};
      done <= 1'b0;
      rdata <= '0;
      cnt <= 8'h00;
      isWr <= 1'b0;
    end else begin
      state <= next_state;
      pins <= next_pins;
      done <= next_done;
      rdata <= next_rdata;
      cnt <= next_cnt;
      isWr <= next_isWr;
    end
  end
endmodule
`default_nettype wire

// ### hdl/fels_ctrl.sv
// Notes on behaviour
// R01: Whole-array erase is six writes: unlock, unlock, set-up, unlock, unlock, erase.
// R02: Device preprograms and verifies before erasing; host supplies nothing.
// R03: After erase the device returns to array read, addresses no longer latched.
// R04: Host decides completion from poll, toggle and erase toggle bits; the controller compares only the toggle bit across two reads.
// R05: Device ignores every command, suspend included, during whole-array erase.
// R06: Hardware reset aborts an erase; host then reissues the whole sequence.
// R07: No secure sector, identification or query access while erasing.
// R08: Sector erase: five set-up writes, then erase command at sector address.
// R09: Device opens a 50 us window accepting further sector erase writes.
// R10: Host spaces further sector writes under 50 us apart.
// R11: Window timed from final write strobe rise; expiry on erase timer bit.
// R12: Once sector erase runs, only suspend is accepted.
// R13: Suspend valid only in sector erase or its window.
// R14: Suspend acts within 20 us, or at once inside the window.
// R15: Suspended: other sectors readable and programmable; suspended ones give status.
// R16: Poll bit, or toggle plus erase toggle, tell erasing from suspended.
// R17: Program during suspend reports status, then returns to suspend-read.
// R18: Resume is written at the suspended sector address; extra resumes ignored.
// R19: Lock register holds one-time bits, readable after an access delay.
// R20: Lock entry precedes lock commands; array access blocked until exit. Controller refuses read and erase in lock mode but allows poll.
// R21: Without lock exit the device hangs until hardware reset.
// R22: Lock program setting both protection mode bits aborts.
// R23: Sequence out of order before erase command is discarded.
`timescale 1ns/1ps
`default_nettype none
`include "fels_defs.svh"
module fels_ctrl
  import fels_pkg::*;
#(
  parameter logic [15:0] WINDOW_CYC =
    16'(`FELS_WINDOW_NS / `FELS_CLK_NS),
  parameter logic [15:0] RST_CYC =
    16'((`FELS_RST_NS + `FELS_CLK_NS - 1) / `FELS_CLK_NS),
  // Command codes and unlock addresses: arbitrary defaults, set per part
  parameter logic [`FELS_ADDR_W-1:0] UNLK1_ADDR = 24'h000001,
  parameter logic [`FELS_ADDR_W-1:0] UNLK2_ADDR = 24'h000002,
  parameter logic [7:0] UNLK1_DATA = 8'h11,
  parameter logic [7:0] UNLK2_DATA = 8'h22,
  parameter logic [7:0] CODE_SETUP = 8'h33,
  parameter logic [7:0] CODE_CHIP = 8'h44,
  parameter logic [7:0] CODE_SECTOR = 8'h55,
  parameter logic [7:0] CODE_RESUME = 8'h66,
  parameter logic [7:0] CODE_LOCK_ENTRY = 8'h77,
  parameter logic [7:0] CODE_LOCK_PROG = 8'h88,
  parameter logic [7:0] CODE_EXIT1 = 8'h99,
  parameter logic [7:0] CODE_EXIT2 = 8'h00
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output fels_pins_s flPins,
  input wire logic [`FELS_DATA_W-1:0] flDqIn,
  output logic flResetN
);
  fels_state_e state, next_state;
  fels_op_e curOp, next_curOp;
  fels_erase_e eraseKind, next_eraseKind;
  logic [2:0] step, next_step;
  logic [15:0] cnt, next_cnt, windowCnt, next_windowCnt;
  logic [`FELS_ADDR_W-1:0] target, next_target, suspSector, next_suspSector;
  logic [`FELS_DATA_W-1:0] wdata, next_wdata, lastRead, next_lastRead;
  logic lockMode, next_lockMode, suspended, next_suspended;
  logic refused, next_refused, next_flResetN;
  logic wrPend, next_wrPend;
  logic [7:0] wrAddr, next_wrAddr;
  logic [31:0] next_hrdata, statusWord;
  logic cycStart, cycDone, cmdReq, allowed;
  fels_cyc_s cyc;
  fels_op_e reqOp;
  logic [`FELS_DATA_W-1:0] cycRdata;

  function automatic logic [2:0] seqLast(input fels_op_e op);
    case (op)
      OP_CHIP, OP_SECTOR: seqLast = 3'd5; // R01 R08
      OP_LOCK_ENTRY: seqLast = 3'd2;
      OP_LOCK_PROG, OP_LOCK_EXIT, OP_POLL: seqLast = 3'd1;
      default: seqLast = 3'd0;
    endcase
  endfunction

  function automatic fels_cyc_s cmdWr(input logic [`FELS_ADDR_W-1:0] a,
                                      input logic [7:0] d);
    cmdWr = '{wr: 1'b1, addr: a, data: {8'h00, d}};
  endfunction

  // Every operand comes in as an argument so the assign sees each change
  function automatic fels_cyc_s seqCycle(input fels_op_e op,
                                         input logic [2:0] s,
                                         input logic [`FELS_ADDR_W-1:0] tgt,
                                         input logic [`FELS_ADDR_W-1:0] sus,
                                         input logic [7:0] wd);
    seqCycle = '{wr: 1'b0, addr: tgt, data: '0};
    case (op)
      OP_CHIP, OP_SECTOR, OP_LOCK_ENTRY: begin
        case (s)
          3'd0, 3'd3: seqCycle = cmdWr(UNLK1_ADDR, UNLK1_DATA);
          3'd1, 3'd4: seqCycle = cmdWr(UNLK2_ADDR, UNLK2_DATA);
          3'd2: seqCycle = cmdWr(UNLK1_ADDR,
                  op == OP_LOCK_ENTRY ? CODE_LOCK_ENTRY : CODE_SETUP);
          default: seqCycle = (op == OP_CHIP) ?
                     cmdWr(UNLK1_ADDR, CODE_CHIP) : // R01
                     cmdWr(tgt, CODE_SECTOR); // R08
        endcase
      end
      OP_SECTOR_ADD: seqCycle = cmdWr(tgt, CODE_SECTOR); // R09
      OP_SUSPEND: seqCycle = cmdWr(tgt, `FELS_CODE_SUSPEND);
      OP_RESUME: seqCycle = cmdWr(sus, CODE_RESUME); // R18
      OP_LOCK_PROG: seqCycle = (s == 3'd0) ?
                      cmdWr('0, CODE_LOCK_PROG) : cmdWr('0, wd);
      OP_LOCK_READ: seqCycle.addr = '0;
      OP_LOCK_EXIT: seqCycle = cmdWr('0, (s == 3'd0) ? CODE_EXIT1
                                                     : CODE_EXIT2);
      default: seqCycle.wr = 1'b0;
    endcase
  endfunction

  assign cmdReq = wrPend && (wrAddr == `FELS_OFF_CMD);
  assign reqOp = fels_op_e'(hwdata[3:0]);
  assign cycStart = (state == ST_ISSUE);
  assign cyc = seqCycle(curOp, step, target, suspSector, wdata[7:0]);
  assign statusWord = {25'h0, refused, (windowCnt != 16'h0000), eraseKind,
                       suspended, lockMode, (state != ST_IDLE)};

  // Host keeps its own command order; anything else is refused
  always_comb begin
    case (reqOp)
      OP_CHIP, OP_SECTOR, OP_LOCK_ENTRY:
        allowed = !lockMode && eraseKind == ERK_NONE; // R20 R07
      OP_SECTOR_ADD: allowed = eraseKind == ERK_SECTOR && !suspended &&
                               windowCnt != 16'h0000; // R10
      OP_SUSPEND: allowed = eraseKind == ERK_SECTOR && !suspended; // R13 R05
      OP_RESUME: allowed = suspended; // R18
      OP_READ: allowed = !lockMode; // R20
      OP_POLL: allowed = !suspended;
      OP_LOCK_PROG: allowed = lockMode &&
        !(wdata[`FELS_LOCK_PERSIST_BIT] &&
          wdata[`FELS_LOCK_PASSWORD_BIT]); // R22
      OP_LOCK_READ, OP_LOCK_EXIT: allowed = lockMode; // R20 R21
      OP_HW_RESET: allowed = 1'b1;
      default: allowed = 1'b0;
    endcase
  end

  always_comb begin
    next_wrPend = hsel && hready && htrans[1] && hwrite;
    next_wrAddr = haddr[7:0];
    next_hrdata = 32'h0000_0000;
    if (hsel && hready && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        `FELS_OFF_ADDR: next_hrdata = {8'h00, target};
        `FELS_OFF_WDATA: next_hrdata = {16'h0000, wdata};
        `FELS_OFF_STATUS: next_hrdata = statusWord;
        `FELS_OFF_RDATA: next_hrdata = {16'h0000, lastRead};
        default: next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_comb begin
    next_state = state;
    next_curOp = curOp;
    next_step = step;
    next_cnt = cnt;
    next_eraseKind = eraseKind;
    next_target = target;
    next_suspSector = suspSector;
    next_wdata = wdata;
    next_lastRead = lastRead;
    next_lockMode = lockMode;
    next_suspended = suspended;
    next_flResetN = 1'b1;
    next_windowCnt = (windowCnt != 16'h0000) ? windowCnt - 16'h0001
                                             : windowCnt;
    next_refused = refused;
    if (wrPend && wrAddr == `FELS_OFF_ADDR && state == ST_IDLE) begin
      next_target = hwdata[`FELS_ADDR_W-1:0];
    end
    if (wrPend && wrAddr == `FELS_OFF_WDATA && state == ST_IDLE) begin
      next_wdata = hwdata[`FELS_DATA_W-1:0];
    end
    if (wrPend && wrAddr == `FELS_OFF_STATUS &&
        hwdata[`FELS_ST_REFUSED]) begin
      next_refused = 1'b0;
    end
    case (state)
      ST_IDLE: begin
        if (cmdReq && allowed) begin
          next_curOp = reqOp;
          next_step = 3'd0;
          next_cnt = RST_CYC;
          next_state = (reqOp == OP_HW_RESET) ? ST_RST : ST_ISSUE;
          // Pulse starts here so it lasts exactly RST_CYC cycles
          next_flResetN = (reqOp != OP_HW_RESET); // R06
        end
      end
      ST_ISSUE: next_state = ST_WAIT;
      ST_WAIT: begin
        if (cycDone) begin
          next_state = ST_IDLE;
          if (!cyc.wr) begin
            next_lastRead = cycRdata;
          end
          if (step != seqLast(curOp)) begin
            // Whole sequence goes out back to back; no partial sequences
            next_step = step + 3'd1; // R23
            next_state = ST_ISSUE;
          end else begin
            case (curOp)
              OP_CHIP: next_eraseKind = ERK_CHIP;
              OP_SECTOR, OP_SECTOR_ADD: begin
                next_eraseKind = ERK_SECTOR;
                next_windowCnt = WINDOW_CYC; // R10 R11
                if (curOp == OP_SECTOR) begin
                  next_suspSector = target;
                end
              end
              OP_SUSPEND: begin
                next_suspended = 1'b1;
                next_windowCnt = 16'h0000; // R14
              end
              OP_RESUME: next_suspended = 1'b0; // R18
              OP_LOCK_ENTRY: next_lockMode = 1'b1; // R20
              OP_LOCK_EXIT: next_lockMode = 1'b0; // R21
              OP_POLL: begin
                // Toggle bit stable between two reads means finished
                if (lastRead[`FELS_TOGGLE_BIT] ==
                    cycRdata[`FELS_TOGGLE_BIT]) begin
                  next_eraseKind = ERK_NONE; // R04
                  next_windowCnt = 16'h0000;
                end else begin
                  next_state = ST_ISSUE; // R04
                end
              end
              default: next_step = step;
            endcase
          end
        end
      end
      ST_RST: begin
        next_flResetN = 1'b0; // R06
        next_cnt = cnt - 16'h0001;
        if (cnt == 16'h0001) begin
          next_flResetN = 1'b1;
          // Erase aborted; software must reissue the full sequence
          next_eraseKind = ERK_NONE; // R06
          next_suspended = 1'b0;
          next_lockMode = 1'b0; // R21
          next_windowCnt = 16'h0000;
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // A refusal in the same cycle as its clear still sets the flag
    if (cmdReq && (!allowed || state != ST_IDLE)) begin
      next_refused = 1'b1; // R05 R12
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      curOp <= OP_NONE;
      step <= 3'd0;
      cnt <= 16'h0000;
      eraseKind <= ERK_NONE;
      target <= '0;
      suspSector <= '0;
      wdata <= '0;
      lastRead <= '0;
      lockMode <= 1'b0;
      suspended <= 1'b0;
      refused <= 1'b0;
      windowCnt <= 16'h0000;
      flResetN <= 1'b1;
      wrPend <= 1'b0;
      wrAddr <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      state <= next_state;
      curOp <= next_curOp;
      step <= next_step;
      cnt <= next_cnt;
      eraseKind <= next_eraseKind;
      target <= next_target;
      suspSector <= next_suspSector;
      wdata <= next_wdata;
      lastRead <= next_lastRead;
      lockMode <= next_lockMode;
      suspended <= next_suspended;
      refused <= next_refused;
      windowCnt <= next_windowCnt;
      flResetN <= next_flResetN;
      wrPend <= next_wrPend;
      wrAddr <= next_wrAddr;
      hrdata <= next_hrdata;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  fels_bus_cycle u_cycle (
    .mclk(mclk),
    .rst(rst),
    .start(cycStart),
    .cyc(cyc),
    .dqIn(flDqIn),
    .pins(flPins),
    .done(cycDone),
    .rdata(cycRdata)
  );

  AST_CHIP_SIXTH: assert property (@(posedge mclk) disable iff (rst) // R01
    cycStart && curOp == OP_CHIP && step == 3'd5 |->
      cyc.wr && cyc.data == {8'h00, CODE_CHIP})
    else $error("sixth chip erase write carries wrong code");
  AST_SECTOR_AT_TARGET: assert property ( // R08
    @(posedge mclk) disable iff (rst)
    cycStart && curOp == OP_SECTOR && step == 3'd5 |->
      cyc.addr == target && cyc.data == {8'h00, CODE_SECTOR}
      ##1 state == ST_WAIT)
    else $error("sector erase command not at target sector");
  AST_RESUME_ADDR: assert property (@(posedge mclk) disable iff (rst) // R18
    cycStart && curOp == OP_RESUME |-> cyc.addr == suspSector)
    else $error("resume not written at suspended sector");
  AST_LOCK_BLOCKS_ARRAY: assert property (@(posedge mclk) // R20
    disable iff (rst) state == ST_IDLE && cmdReq && lockMode &&
      (reqOp == OP_READ || reqOp == OP_CHIP) |=> refused && state == ST_IDLE)
    else $error("array access issued inside lock command set");
  AST_LOCK_BOTH_MODES: assert property ( // R22
    @(posedge mclk) disable iff (rst)
    state == ST_IDLE && cmdReq && reqOp == OP_LOCK_PROG &&
      wdata[`FELS_LOCK_PERSIST_BIT] && wdata[`FELS_LOCK_PASSWORD_BIT]
      |=> state == ST_IDLE)
    else $error("lock program with both mode bits issued");
  AST_WINDOW_SPACING: assert property ( // R10
    @(posedge mclk) disable iff (rst)
    state == ST_IDLE && $past(state) == ST_WAIT &&
      $past(curOp) == OP_SECTOR_ADD |-> windowCnt == WINDOW_CYC)
    else $error("sector window not restarted by added sector");
  AST_SUSPEND_ONLY_SECTOR: assert property (@(posedge mclk) // R13
    disable iff (rst) cycStart && curOp == OP_SUSPEND |->
      eraseKind == ERK_SECTOR && !suspended)
    else $error("suspend issued outside sector erase");
  AST_RESET_ABORTS: assert property ( // R06
    @(posedge mclk) disable iff (rst)
    $rose(flResetN) |-> eraseKind == ERK_NONE && !suspended &&
      !lockMode && $past(flResetN, 2) == 1'b0)
    else $error("hardware reset did not clear erase state");
  AST_POLL_DONE: assert property (@(posedge mclk) disable iff (rst) // R04
    $fell(eraseKind != ERK_NONE) |-> $past(curOp) == OP_POLL ||
      $past(state) == ST_RST)
    else $error("erase ended without poll result");
endmodule
`default_nettype wire

// ### hdl/fels_defs.svh
`ifndef FELS_DEFS_SVH
`define FELS_DEFS_SVH
`define FELS_ADDR_W 24
`define FELS_DATA_W 16
`define FELS_OFF_CMD 8'h00
`define FELS_OFF_ADDR 8'h04
`define FELS_OFF_WDATA 8'h08
`define FELS_OFF_STATUS 8'h0C
`define FELS_OFF_RDATA 8'h10
`define FELS_ST_BUSY 0
`define FELS_ST_LOCK 1
`define FELS_ST_SUSP 2
`define FELS_ST_KIND_LO 3
`define FELS_ST_WINDOW 5
`define FELS_ST_REFUSED 6
`define FELS_CODE_SUSPEND 8'hB0
`define FELS_TOGGLE_BIT 6
`define FELS_LOCK_PERSIST_BIT 1
`define FELS_LOCK_PASSWORD_BIT 2
`define FELS_CLK_NS 5
`define FELS_WINDOW_NS 50000
`define FELS_RST_NS 500
`define FELS_STROBE_NS 60
`define FELS_ACCESS_NS 100
`endif

// ### hdl/fels_pkg.sv
package fels_pkg;
`include "fels_defs.svh"
  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_CHIP = 4'h1, OP_SECTOR = 4'h2, OP_SECTOR_ADD = 4'h3,
    OP_SUSPEND = 4'h4, OP_RESUME = 4'h5, OP_READ = 4'h6, OP_POLL = 4'h7,
    OP_LOCK_ENTRY = 4'h8, OP_LOCK_PROG = 4'h9, OP_LOCK_READ = 4'hA,
    OP_LOCK_EXIT = 4'hB, OP_HW_RESET = 4'hC
  } fels_op_e;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001, ST_ISSUE = 4'b0010, ST_WAIT = 4'b0100,
    ST_RST = 4'b1000
  } fels_state_e;
  typedef enum logic [3:0] {
    CY_IDLE = 4'b0001, CY_SETUP = 4'b0010, CY_STROBE = 4'b0100,
    CY_HOLD = 4'b1000
  } fels_cyc_e;
  typedef enum logic [1:0] {
    ERK_NONE = 2'h0, ERK_CHIP = 2'h1, ERK_SECTOR = 2'h2
  } fels_erase_e;
  typedef struct packed {
    logic wr;
    logic [`FELS_ADDR_W-1:0] addr;
    logic [`FELS_DATA_W-1:0] data;
  } fels_cyc_s;
  typedef struct packed {
    logic [`FELS_ADDR_W-1:0] addr;
    logic [`FELS_DATA_W-1:0] dq;
    logic dqDriveN;
    logic ceN;
    logic oeN;
    logic weN;
  } fels_pins_s;
endpackage

// ### tb/fels_flash_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "fels_defs.svh"
module fels_flash_model
  import fels_pkg::*;
#(
  parameter int WIN_CYC = 200,
  parameter int ERASE_CYC = 2000
) (
  input wire logic mclk,
  input wire fels_pins_s pins,
  input wire logic resetN,
  output logic [`FELS_DATA_W-1:0] dqOut
);
  // Codes match the controller's default parameters
  localparam logic [23:0] U1 = 24'h000001;
  localparam logic [23:0] U2 = 24'h000002;
  logic [2:0] seq = 0;
  logic [1:0] kind = 0;
  logic susp = 0, lockMode = 0, progArm = 0, exitArm = 0;
  logic winOpen = 0, tog = 0, prevWe = 1, prevOe = 1;
  logic [255:0] sel = '0;
  logic [7:0] lockReg = 8'h00;
  logic [15:0] rdVal = 0, lastVal = 0;
  int winCnt = 0, eraseCnt = 0;
  logic [7:0] d;
  logic [23:0] a;
  assign d = pins.dq[7:0];
  assign a = pins.addr;
  // Released bus shows the inverse, so a stale sample never matches
  assign dqOut = (!pins.ceN && !pins.oeN) ? rdVal : ~lastVal;
  always @(posedge mclk) begin
    prevWe <= pins.weN;
    prevOe <= pins.oeN;
    if (pins.oeN && !prevOe) lastVal <= rdVal;
    if (!resetN) begin
      kind <= 0; seq <= 0; susp <= 0; lockMode <= 0; winOpen <= 0;
      sel <= '0; progArm <= 0; exitArm <= 0;
    end else begin
      if (kind != 0 && !susp && !winOpen) begin
        if (eraseCnt >= ERASE_CYC) begin
          kind <= 0;
          sel <= '0;
        end else eraseCnt <= eraseCnt + 1;
      end
      if (winOpen) begin
        if (winCnt >= WIN_CYC) winOpen <= 0;
        else winCnt <= winCnt + 1;
      end
      if (pins.weN && !prevWe && !pins.ceN) begin
        if (lockMode) begin
          if (progArm) begin
            if (!(d[1] && d[2])) lockReg <= lockReg | d;
            progArm <= 0;
          end else if (d == 8'h88) progArm <= 1;
          else if (exitArm && d == 8'h00) lockMode <= 0;
          else exitArm <= (d == 8'h99);
        end else if (kind == ERK_CHIP) begin
        end else if (kind == ERK_SECTOR) begin
          if (d == `FELS_CODE_SUSPEND && !susp) begin
            susp <= 1;
            winOpen <= 0;
          end else if (susp && d == 8'h66 && sel[a[23:16]]) susp <= 0;
          else if (winOpen && d == 8'h55) begin
            sel[a[23:16]] <= 1;
            winCnt <= 0;
          end
        end else begin
          case (seq)
            3'd0, 3'd3: seq <= (a == U1 && d == 8'h11) ? seq + 3'd1 : 3'd0;
            3'd1, 3'd4: seq <= (a == U2 && d == 8'h22) ? seq + 3'd1 : 3'd0;
            3'd2: begin
              seq <= (d == 8'h33) ? 3'd3 : 3'd0;
              lockMode <= (d == 8'h77);
            end
            default: begin
              seq <= 0;
              eraseCnt <= 0;
              if (d == 8'h44) kind <= ERK_CHIP;
              else if (d == 8'h55) begin
                kind <= ERK_SECTOR;
                sel[a[23:16]] <= 1;
                winOpen <= 1;
                winCnt <= 0;
              end
            end
          endcase
        end
      end
      if (!pins.oeN && prevOe && !pins.ceN) begin
        tog <= ~tog;
        if (lockMode) rdVal <= (a == 0) ? {8'h00, lockReg} : 16'hFFFF;
        else if (kind != 0 && (!susp || sel[a[23:16]]))
          rdVal <= {8'h00, susp, susp ? 1'b0 : tog, 2'b00, ~winOpen, tog,
                    2'b00};
        else rdVal <= a[15:0] ^ 16'h5A3C;
      end
    end
  end
endmodule
`default_nettype wire

// ### tb/flash_erase_lock_sequencer_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "fels_defs.svh"
module flash_erase_lock_sequencer_tb;
  import fels_pkg::*;
  logic mclk = 0, rst = 1, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, st, r, y, x = 99787;
  logic [1:0] htrans = 0;
  logic hreadyout, hresp, flResetN;
  logic [15:0] flDqIn;
  fels_pins_s flPins;
  int nFail = 0, nCompared = 0;
  always #2.5 mclk = ~mclk;
  fels_ctrl #(.WINDOW_CYC(16'h00C8), .RST_CYC(16'h0004)) dut (.mclk(mclk),
    .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .flPins(flPins), .flDqIn(flDqIn), .flResetN(flResetN));
  fels_flash_model #(.WIN_CYC(200), .ERASE_CYC(2000)) flash (.mclk(mclk),
    .pins(flPins), .resetN(flResetN), .dqOut(flDqIn));
  task printVerdict;
    $display("counts: %0d failed of %0d compared", nFail, nCompared);
    if (nFail == 0 && nCompared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    nCompared++;
    if (got !== exp) begin
      nFail++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    hsel <= 1; htrans <= 2'h2; hwrite <= w; haddr <= {24'h0, a};
    k = 0;
    do begin @(posedge mclk); k++; end while (hreadyout !== 1'b1 && k < 99);
    htrans <= 2'h0; hwdata <= d;
    do begin @(posedge mclk); k++; end while (hreadyout !== 1'b1 && k < 99);
    r = hrdata;
    if (k >= 99) begin chk(k, 0); printVerdict(); end
  endtask
  // Bounded poll of the busy flag; long enough for a full erase
  task waitIdle;
    int k;
    for (k = 0; k < 9000; k++) begin
      xfer(0, `FELS_OFF_STATUS, 0);
      if (r[0] === 1'b0) break;
    end
    st = r;
    if (k >= 9000) begin chk(1, 0); printVerdict(); end
  endtask
  task op(input logic [3:0] o, input logic rf);
    xfer(1, `FELS_OFF_CMD, {28'h0, o});
    waitIdle();
    chk(st[6], rf);
    xfer(1, `FELS_OFF_STATUS, 32'h40);
  endtask
  task setA(input logic [23:0] a);
    xfer(1, `FELS_OFF_ADDR, {8'h0, a});
  endtask
  task rdArr(input logic [23:0] a);
    setA(a); op(4'h6, 0); xfer(0, `FELS_OFF_RDATA, 0);
  endtask
  function logic [31:0] expArr(input logic [23:0] a);
    return {16'h0, a[15:0] ^ 16'h5A3C};
  endfunction
  function logic [31:0] nextRnd();
    x = x ^ (x << 13); x = x ^ (x >> 17); x = x ^ (x << 5);
    return x;
  endfunction
  initial begin
    repeat (10) @(posedge mclk);
    rst <= 0;
    @(posedge mclk);
    xfer(0, `FELS_OFF_STATUS, 0); chk(r, 0);
    xfer(0, 8'h20, 0); chk(r, 0);
    chk(hresp, 0);
    repeat (6) begin
      y = nextRnd();
      setA(y[23:0]); xfer(0, `FELS_OFF_ADDR, 0);
      chk(r, {8'h0, y[23:0]});
      rdArr(y[23:0]); chk(r, expArr(y[23:0]));
    end
    op(4'h1, 0); chk(st[4:3], 2'h1);
    op(4'h4, 1);
    op(4'h8, 1);
    op(4'h7, 0); chk(st[4:3], 2'h0);
    rdArr(24'h000123); chk(r, expArr(24'h000123));
    setA(24'h030000); op(4'h2, 0); chk(st[5:3], 3'b110);
    setA(24'h050000); op(4'h3, 0);
    op(4'h4, 0); chk(st[5:2], 4'b0101);
    rdArr(24'h070010); chk(r, expArr(24'h070010));
    rdArr(24'h050000); chk(r[7:6], 2'b10);
    op(4'h5, 0); chk(st[2], 1'b0);
    op(4'h7, 0); chk(st[4:3], 2'h0);
    setA(24'h030000); op(4'h2, 0);
    repeat (260) @(posedge mclk);
    xfer(0, `FELS_OFF_STATUS, 0); chk(r[5], 1'b0);
    op(4'h3, 1);
    op(4'hC, 0); chk(st[4:3], 2'h0);
    rdArr(24'h030044); chk(r, expArr(24'h030044));
    op(4'h8, 0); chk(st[1], 1'b1);
    op(4'h6, 1);
    op(4'h1, 1);
    xfer(1, `FELS_OFF_WDATA, 32'h6); op(4'h9, 1);
    xfer(1, `FELS_OFF_WDATA, 32'h2); op(4'h9, 0);
    op(4'hA, 0); xfer(0, `FELS_OFF_RDATA, 0); chk(r, 32'h2);
    op(4'hB, 0); chk(st[1], 1'b0);
    rdArr(24'h000200); chk(r, expArr(24'h000200));
    op(4'h8, 0); op(4'hC, 0); chk(st[1], 1'b0);
    printVerdict();
  end
endmodule
`default_nettype wire
